// >>> rtl/xlat_pkg.sv
`default_nettype none
package xlat_pkg;
    // Geometry
    localparam int TLB_ENTRIES = 128;
    localparam int STACK_DEPTH = 6;
    localparam int IDX_W       = 7;
    localparam int ID_W        = 3;
    localparam int VPN_W       = 13;
    localparam int ORG_W       = 18;
    localparam int SLEN_W      = 8;
    localparam int CNT_W       = 5;
    localparam logic [CNT_W-1:0] WALK_MIN_CYC = 5'h08;
    localparam logic [CNT_W-1:0] WALK_MAX_CYC = 5'h1A;
    localparam logic [CNT_W-1:0] CNT_SAT      = 5'h1F;
    // Address arithmetic
    localparam int SEG_ORG_SHIFT = 6;
    localparam int SEG_IDX_SHIFT = 2;
    localparam int PTO_SHIFT     = 3;
    localparam int PIDX_SHIFT    = 1;
    // Register byte offsets
    localparam logic [11:0] REG_CR0    = 12'h000;
    localparam logic [11:0] REG_CR1    = 12'h004;
    localparam logic [11:0] REG_MODE   = 12'h008;
    localparam logic [11:0] REG_CMD    = 12'h00C;
    localparam logic [11:0] REG_KEYADR = 12'h010;
    localparam logic [11:0] REG_STATUS = 12'h014;
    // Field positions
    localparam int CR0_PG_LSB  = 8;
    localparam int CR0_SEG_LSB = 11;
    localparam int CR1_LEN_LSB = 0;
    localparam int CR1_ORG_LSB = 8;
    localparam int CMD_LOAD    = 0;
    localparam int CMD_PURGE   = 1;
    localparam int CMD_CONFIG  = 2;
    localparam int CMD_RETRY   = 3;
    localparam int CMD_KEYSET  = 4;
    localparam int CMD_MCCLR   = 5;
    localparam int ST_DEGR     = 4;
    localparam int ST_MC       = 5;
    localparam int ST_BUSY     = 6;
    localparam int SE_PTL_LSB  = 28;
    localparam int SE_PTO_LSB  = 3;
    localparam int SE_INV      = 0;
    localparam int PTE4_INV    = 3;
    localparam int PTE2_INV    = 2;
    // Size encodings
    localparam logic [1:0] PG_2K   = 2'h1;
    localparam logic [1:0] PG_4K   = 2'h2;
    localparam logic [1:0] SEG_64K = 2'h0;
    localparam logic [1:0] SEG_1M  = 2'h2;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        EXC_NONE = 2'b00,
        EXC_SPEC = 2'b01,
        EXC_SEG  = 2'b10,
        EXC_PAGE = 2'b11
    } exc_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_SEG  = 2'b01,
        S_PAGE = 2'b10,
        S_HOLD = 2'b11
    } walk_state_t;

    typedef struct packed {
        logic        valid;
        exc_t        exc;
        logic [3:0]  key;
        logic [23:0] raddr;
    } xlat_resp_t;

    typedef struct packed {
        logic             valid;
        logic [ORG_W-1:0] origin;
        logic             seg1m;
        logic             pg4k;
    } stack_ent_t;

    // Page number at 2K grain; bit 0 forced low for 4K pages
    function automatic logic [VPN_W-1:0] vpn_f(input logic [23:0] va, input logic pg4k);
        vpn_f = pg4k ? {va[23:12], 1'b0} : va[23:11];
    endfunction

    // Half-disable pins the top index bit low
    function automatic logic [IDX_W-1:0] hash_f(input logic [VPN_W-1:0] vpn, input logic deg);
        logic [IDX_W-1:0] h;
        h = vpn[6:0] ^ {1'b0, vpn[12:7]};
        hash_f = deg ? {1'b0, h[IDX_W-2:0]} : h;
    endfunction
endpackage : xlat_pkg
`default_nettype wire

// >>> rtl/xlat_buffer.sv
// Design decisions made here: register access over APB and the register addresses.
`default_nettype none
module xlat_buffer
    import xlat_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Execution unit side
    input  wire logic        req_valid,
    input  wire logic [23:0] req_vaddr,
    output logic             req_ready,
    output var xlat_resp_t   resp,
    // Processor storage side
    output logic             mem_req,
    output logic      [23:0] mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    input  wire logic [3:0]  mem_key,
    // Machine check
    input  wire logic        buffer_error,
    output logic             machine_check
);
    logic [1:0]        cr0_pg_q, cr0_seg_q;
    logic [ORG_W-1:0]  cr1_org_q;
    logic [SLEN_W-1:0] cr1_len_q;
    logic              mode_q;
    logic [23:0]       keyadr_q;
    logic [31:0]       prdata_q;
    logic              pslverr_q;
    stack_ent_t        stack_q [STACK_DEPTH];
    logic [ID_W-1:0]   ptr_q, active_q;
    logic [ID_W-1:0]   id_q    [TLB_ENTRIES];
    logic [VPN_W-1:0]  tag_q   [TLB_ENTRIES];
    logic [VPN_W-1:0]  frame_q [TLB_ENTRIES];
    logic [3:0]        key_q   [TLB_ENTRIES];
    logic              deg_q, mc_q, mc_pulse_q;
    walk_state_t       state_q;
    logic [23:0]       va_q;
    logic [CNT_W-1:0]  cnt_q, walk_len_q;
    logic [31:0]       se_q;
    xlat_resp_t        resp_q, res_q;
    logic              walked_q, mem_req_q;
    logic [23:0]       mem_addr_q;

    // Bus decode
    logic apb_setup, apb_wr, wr_cmd, op_load, op_clr_all, op_keyset, mode_enter;
    assign pready    = ce;
    assign apb_setup = psel && !penable && ce;
    assign apb_wr    = psel && penable && pwrite && ce;
    assign wr_cmd    = apb_wr && (paddr == REG_CMD);
    assign mode_enter = apb_wr && (paddr == REG_MODE) && pwdata[0] && !mode_q;
    assign op_load   = mode_enter || (wr_cmd && pwdata[CMD_LOAD] && mode_q);
    assign op_clr_all = wr_cmd && (pwdata[CMD_PURGE] || pwdata[CMD_CONFIG]
                        || pwdata[CMD_RETRY]);
    assign op_keyset = wr_cmd && pwdata[CMD_KEYSET];

    // Size decode from control register 0
    logic seg1m, pg4k, spec_bad;
    assign seg1m    = (cr0_seg_q == SEG_1M);
    assign pg4k     = (cr0_pg_q == PG_4K);
    assign spec_bad = !((cr0_seg_q == SEG_64K) || (cr0_seg_q == SEG_1M))
                   || !((cr0_pg_q == PG_2K) || (cr0_pg_q == PG_4K));

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cr0_pg_q  <= PG_4K;
            cr0_seg_q <= SEG_64K;
            cr1_org_q <= '0;
            cr1_len_q <= '0;
            mode_q    <= 1'b0;
            keyadr_q  <= '0;
        end else if (apb_wr) begin
            case (paddr)
                REG_CR0: begin
                    cr0_pg_q  <= pwdata[CR0_PG_LSB +: 2];
                    cr0_seg_q <= pwdata[CR0_SEG_LSB +: 2];
                end
                REG_CR1: begin
                    cr1_org_q <= pwdata[CR1_ORG_LSB +: ORG_W];
                    cr1_len_q <= pwdata[CR1_LEN_LSB +: SLEN_W];
                end
                REG_MODE:   mode_q   <= pwdata[0];
                REG_KEYADR: keyadr_q <= pwdata[23:0];
                default: ;
            endcase
        end
    end

    // Read data staged in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= RST_WORD;
            pslverr_q <= 1'b0;
        end else if (apb_setup) begin
            prdata_q  <= RST_WORD;
            pslverr_q <= 1'b0;
            case (paddr)
                REG_CR0: begin
                    prdata_q[CR0_PG_LSB +: 2]  <= cr0_pg_q;
                    prdata_q[CR0_SEG_LSB +: 2] <= cr0_seg_q;
                end
                REG_CR1: begin
                    prdata_q[CR1_ORG_LSB +: ORG_W]  <= cr1_org_q;
                    prdata_q[CR1_LEN_LSB +: SLEN_W] <= cr1_len_q;
                end
                REG_MODE:   prdata_q[0] <= mode_q;
                REG_CMD:    ;
                REG_KEYADR: prdata_q[23:0] <= keyadr_q;
                REG_STATUS: begin
                    prdata_q[ID_W-1:0] <= active_q;
                    prdata_q[ST_DEGR]  <= deg_q;
                    prdata_q[ST_MC]    <= mc_q;
                    prdata_q[ST_BUSY]  <= (state_q != S_IDLE);
                end
                default: pslverr_q <= 1'b1;
            endcase
        end
    end
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q && psel && penable;

    // Stack compare against current origin and sizes
    logic            match_hit;
    logic [ID_W-1:0] match_id, slot_id;
    always_comb begin
        match_hit = 1'b0;
        match_id  = '0;
        for (int i = 0; i < STACK_DEPTH; i++) begin
            if (stack_q[i].valid && stack_q[i].origin == cr1_org_q
                && stack_q[i].seg1m == seg1m && stack_q[i].pg4k == pg4k) begin
                match_hit = 1'b1;
                match_id  = ID_W'(i + 1);
            end
        end
    end
    assign slot_id = ptr_q + 3'h1;

    // Origin stack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= '0;
            end
            ptr_q    <= '0;
            active_q <= '0;
        end else if (ce && op_load) begin
            if (match_hit) begin
                active_q <= match_id;
            end else begin
                stack_q[ptr_q] <= '{valid: 1'b1, origin: cr1_org_q,
                                    seg1m: seg1m, pg4k: pg4k};
                active_q <= slot_id;
                ptr_q <= (ptr_q == 3'(STACK_DEPTH - 1)) ? 3'h0 : ptr_q + 3'h1;
            end
        end
    end

    // Lookup on the presented address
    logic [VPN_W-1:0] req_vpn, va_vpn;
    logic [IDX_W-1:0] req_idx, va_idx;
    logic             hit;
    logic [23:0]      hit_raddr;
    assign req_vpn = vpn_f(req_vaddr, pg4k);
    assign req_idx = hash_f(req_vpn, deg_q);
    assign hit = (id_q[req_idx] != '0) && (id_q[req_idx] == active_q)
              && (tag_q[req_idx] == req_vpn);
    assign hit_raddr = pg4k ? {frame_q[req_idx][12:1], req_vaddr[11:0]}
                            : {frame_q[req_idx], req_vaddr[10:0]};
    assign va_vpn = vpn_f(va_q, pg4k);
    assign va_idx = hash_f(va_vpn, deg_q);

    // Table walk addressing
    logic [7:0]  seg_idx;
    logic [8:0]  pg_idx;
    logic [3:0]  pg_hi, ptl;
    logic [20:0] pto;
    logic [23:0] seg_addr, pte_addr;
    logic [15:0] pte;
    logic        pte_inv;
    logic [12:0] pte_frame;
    always_comb begin
        seg_idx = seg1m ? {4'h0, req_vaddr[23:20]} : req_vaddr[23:16];
        case ({seg1m, pg4k})
            2'b00:   pg_idx = {4'h0, va_q[15:11]};
            2'b01:   pg_idx = {5'h00, va_q[15:12]};
            2'b10:   pg_idx = va_q[19:11];
            2'b11:   pg_idx = {1'b0, va_q[19:12]};
            default: pg_idx = '0;
        endcase
        case ({seg1m, pg4k})
            2'b00:   pg_hi = pg_idx[4:1];
            2'b01:   pg_hi = pg_idx[3:0];
            2'b10:   pg_hi = pg_idx[8:5];
            2'b11:   pg_hi = pg_idx[7:4];
            default: pg_hi = '0;
        endcase
    end
    assign seg_addr = (24'(cr1_org_q) << SEG_ORG_SHIFT)
                    + (24'(seg_idx) << SEG_IDX_SHIFT);
    assign ptl      = se_q[SE_PTL_LSB +: 4];
    assign pto      = se_q[SE_PTO_LSB +: 21];
    assign pte_addr = (24'(pto) << PTO_SHIFT) + (24'(pg_idx) << PIDX_SHIFT);
    assign pte      = mem_addr_q[1] ? mem_rdata[15:0] : mem_rdata[31:16];
    assign pte_inv  = pg4k ? pte[PTE4_INV] : pte[PTE2_INV];
    assign pte_frame = pg4k ? {pte[15:4], 1'b0} : pte[15:3];

    logic accept, mem_done, fill;
    assign req_ready = (state_q == S_IDLE) && ce;
    assign accept    = req_valid && req_ready;
    assign mem_done  = mem_req_q && mem_ack && ce;
    assign fill      = (state_q == S_PAGE) && mem_done && !pte_inv;

    // Buffer identifiers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < TLB_ENTRIES; i++) begin
                id_q[i] <= '0;
            end
        end else if (ce) begin
            if (fill) begin
                id_q[va_idx] <= active_q;
            end
            for (int i = 0; i < TLB_ENTRIES; i++) begin
                if (op_clr_all) begin
                    id_q[i] <= '0;
                end else if (op_keyset && frame_q[i][12:1] == keyadr_q[23:12]) begin
                    id_q[i] <= '0;
                end else if (op_load && !match_hit && id_q[i] == slot_id) begin
                    id_q[i] <= '0;
                end
            end
        end
    end

    // Buffer payload
    always_ff @(posedge pclk) begin
        if (fill) begin
            tag_q[va_idx]   <= va_vpn;
            frame_q[va_idx] <= pte_frame;
            key_q[va_idx]   <= mem_key;
        end
    end

    // Degradation and machine check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deg_q      <= 1'b0;
            mc_q       <= 1'b0;
            mc_pulse_q <= 1'b0;
        end else if (ce) begin
            mc_pulse_q <= buffer_error;
            if (buffer_error) begin
                deg_q <= 1'b1;
                mc_q  <= 1'b1;
            end else if (wr_cmd && pwdata[CMD_MCCLR]) begin
                mc_q <= 1'b0;
            end
        end
    end
    assign machine_check = mc_pulse_q;

    // Translation sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= S_IDLE;
            va_q       <= '0;
            cnt_q      <= '0;
            walk_len_q <= '0;
            se_q       <= '0;
            res_q      <= '0;
            resp_q     <= '0;
            walked_q   <= 1'b0;
            mem_req_q  <= 1'b0;
            mem_addr_q <= '0;
        end else if (ce) begin
            resp_q.valid <= 1'b0;
            walked_q     <= 1'b0;
            if (state_q != S_IDLE && cnt_q != CNT_SAT) begin
                cnt_q <= cnt_q + 5'h01;
            end
            case (state_q)
                S_IDLE: if (accept) begin
                    va_q <= req_vaddr;
                    cnt_q <= 5'h01;
                    if (!mode_q) begin
                        resp_q <= '{valid: 1'b1, exc: EXC_NONE, key: 4'h0,
                                    raddr: req_vaddr};
                    end else if (hit) begin
                        resp_q <= '{valid: 1'b1, exc: EXC_NONE, key: key_q[req_idx],
                                    raddr: hit_raddr};
                    end else if (spec_bad) begin
                        resp_q <= '{valid: 1'b1, exc: EXC_SPEC, key: 4'h0,
                                    raddr: 24'h00_0000};
                    end else if ({4'h0, seg_idx[7:4]} > cr1_len_q) begin
                        resp_q <= '{valid: 1'b1, exc: EXC_SEG, key: 4'h0,
                                    raddr: 24'h00_0000};
                    end else begin
                        state_q    <= S_SEG;
                        mem_req_q  <= 1'b1;
                        mem_addr_q <= seg_addr;
                    end
                end
                S_SEG: if (mem_done) begin
                    se_q <= mem_rdata;
                    if (mem_rdata[SE_INV]) begin
                        res_q     <= '{valid: 1'b1, exc: EXC_SEG, key: 4'h0,
                                       raddr: 24'h00_0000};
                        mem_req_q <= 1'b0;
                        state_q   <= S_HOLD;
                    end else begin
                        mem_req_q <= 1'b0;
                        state_q   <= S_PAGE;
                    end
                end
                S_PAGE: begin
                    if (!mem_req_q) begin
                        if (pg_hi > ptl) begin
                            res_q   <= '{valid: 1'b1, exc: EXC_PAGE, key: 4'h0,
                                         raddr: 24'h00_0000};
                            state_q <= S_HOLD;
                        end else begin
                            mem_req_q  <= 1'b1;
                            mem_addr_q <= pte_addr;
                        end
                    end else if (mem_done) begin
                        mem_req_q <= 1'b0;
                        state_q   <= S_HOLD;
                        if (pte_inv) begin
                            res_q <= '{valid: 1'b1, exc: EXC_PAGE, key: 4'h0,
                                       raddr: 24'h00_0000};
                        end else begin
                            res_q <= '{valid: 1'b1, exc: EXC_NONE, key: mem_key,
                                       raddr: pg4k ? {pte_frame[12:1], va_q[11:0]}
                                                   : {pte_frame, va_q[10:0]}};
                        end
                    end
                end
                S_HOLD: if (cnt_q >= WALK_MIN_CYC - 5'h01) begin
                    resp_q     <= res_q;
                    walked_q   <= 1'b1;
                    walk_len_q <= cnt_q + 5'h01;
                    state_q    <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
    assign resp     = resp_q;
    assign mem_req  = mem_req_q;
    assign mem_addr = mem_addr_q;

    // Checks
    property p_hit_fast;
        @(posedge pclk) disable iff (!presetn)
        (accept && mode_q && hit) |=> (resp_q.valid && resp_q.exc == EXC_NONE);
    endproperty
    a_hit_fast: assert property (p_hit_fast) else $error("hit not answered next cycle");

    property p_walk_min;
        @(posedge pclk) disable iff (!presetn)
        (resp_q.valid && walked_q) |-> (walk_len_q >= WALK_MIN_CYC);
    endproperty
    a_walk_min: assert property (p_walk_min) else $error("walk answered too early");

    property p_seg_addr;
        @(posedge pclk) disable iff (!presetn)
        (accept && mode_q && !hit && !spec_bad && {4'h0, seg_idx[7:4]} <= cr1_len_q)
        |=> (mem_req && mem_addr == $past(seg_addr));
    endproperty
    a_seg_addr: assert property (p_seg_addr) else $error("segment fetch wrong");

    property p_page_exc;
        @(posedge pclk) disable iff (!presetn)
        (state_q == S_PAGE && mem_done && pte_inv) |=> (res_q.exc == EXC_PAGE && !fill);
    endproperty
    a_page_exc: assert property (p_page_exc) else $error("invalid page not excepted");

    property p_spec;
        @(posedge pclk) disable iff (!presetn)
        (accept && mode_q && !hit && spec_bad) |=> (resp_q.valid && resp_q.exc == EXC_SPEC
                                                    && state_q == S_IDLE);
    endproperty
    a_spec: assert property (p_spec) else $error("bad size setting not excepted");

    logic any_valid;
    always_comb begin
        any_valid = 1'b0;
        for (int i = 0; i < TLB_ENTRIES; i++) begin
            any_valid = any_valid || (id_q[i] != '0);
        end
    end
    property p_purge_all;
        @(posedge pclk) disable iff (!presetn)
        (op_clr_all && ce) |=> !any_valid;
    endproperty
    a_purge_all: assert property (p_purge_all) else $error("entries survive purge");

    property p_degrade;
        @(posedge pclk) disable iff (!presetn)
        (buffer_error && ce) |=> (machine_check && deg_q) ##1 deg_q;
    endproperty
    a_degrade: assert property (p_degrade) else $error("error did not degrade");

    property p_match_active;
        @(posedge pclk) disable iff (!presetn)
        (op_load && match_hit && ce) |=> (active_q == $past(match_id)
                                          && ptr_q == $past(ptr_q));
    endproperty
    a_match_active: assert property (p_match_active) else $error("match not activated");
endmodule // xlat_buffer
`default_nettype wire

// >>> dv/storage_model.sv
`default_nettype none
module storage_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Table fetch port
    input  wire logic        mem_req,
    input  wire logic [23:0] mem_addr,
    input  wire logic [1:0]  delay,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata,
    output logic      [3:0]  mem_key
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] KEY = 4'h9;
    logic [31:0] mem [0:4095];
    logic [1:0]  cnt_q;
    initial foreach (mem[i]) mem[i] = 32'h0000_0000;
    // Data flips outside the ack cycle so a stale sample shows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h0000_0000;
            mem_key   <= 4'h0;
            cnt_q     <= 2'h0;
        end else if (mem_req && !mem_ack && cnt_q == delay) begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem[mem_addr[13:2]];
            mem_key   <= KEY;
            cnt_q     <= 2'h0;
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            mem_key   <= ~mem_key;
            cnt_q     <= (mem_req && !mem_ack) ? cnt_q + 2'h1 : 2'h0;
        end
    end
endmodule // storage_model
`default_nettype wire

// >>> dv/tb.sv
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
    $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import xlat_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, perr, req_valid = 1'b0, req_ready, buffer_error = 1'b0;
    logic [23:0] req_vaddr = 24'h00_0000, mem_addr;
    logic        mem_req, mem_ack, machine_check;
    logic [31:0] mem_rdata;
    logic [3:0]  mem_key;
    logic [1:0]  delay = 2'h0;
    xlat_resp_t  resp, rv;
    int          bad_count = 0, checked = 0, n;
    localparam logic [23:0] VA = 24'h12_3456;
    always #2.5 pclk = ~pclk;
    xlat_buffer xlat_buffer_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_vaddr(req_vaddr),
        .req_ready(req_ready), .resp(resp), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_key(mem_key),
        .buffer_error(buffer_error), .machine_check(machine_check));
    storage_model storage_model_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .delay(delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_key(mem_key));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic xl(input logic [23:0] va);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_vaddr <= va;
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        n = 1;
        #1;
        while (resp.valid !== 1'b1 && n < 60) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (resp.valid !== 1'b1) begin
            bad_count++;
            $display("Error %0t: translation not answered", $time);
        end
        rv = resp;
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        storage_model_i.mem[12'h412] = 32'hF000_2000;
        storage_model_i.mem[12'h801] = 32'h0000_ABC0;
        storage_model_i.mem[12'h802] = 32'h0000_0008;
        storage_model_i.mem[12'h413] = 32'h0000_0001;
        apb(1'b0, REG_CR0, 32'h0);
        `CHK(rd, 32'h0000_0200)
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK(rd[2:0], 3'h0)
        apb(1'b0, 12'h020, 32'h0);
        `CHK(perr, 1'b1)
        xl(VA);
        `CHK({rv.raddr, n == 1}, {VA, 1'b1})
        apb(1'b1, REG_CR1, 32'h0000_400F);
        apb(1'b1, REG_MODE, 32'h0000_0001);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK(rd[2:0], 3'h1)
        xl(VA);
        `CHK({rv.exc, rv.key, rv.raddr, n == 8}, {EXC_NONE, 4'h9, 24'hAB_C456, 1'b1})
        xl(VA);
        `CHK({rv.raddr, n == 1}, {24'hAB_C456, 1'b1})
        apb(1'b1, REG_CMD, 32'h0000_0002);
        delay <= 2'h3;
        xl(VA);
        `CHK({rv.raddr, n > 8 && n <= WALK_MAX_CYC}, {24'hAB_C456, 1'b1})
        apb(1'b1, REG_CR1, 32'h0000_C00F);
        apb(1'b1, REG_CMD, 32'h0000_0001);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK(rd[2:0], 3'h2)
        xl(VA);
        `CHK(rv.exc, EXC_PAGE)
        apb(1'b1, REG_CR1, 32'h0000_400F);
        apb(1'b1, REG_CMD, 32'h0000_0001);
        xl(VA);
        `CHK({rv.raddr, n == 1}, {24'hAB_C456, 1'b1})
        xl(24'h12_5000);
        `CHK(rv.exc, EXC_PAGE)
        apb(1'b1, REG_KEYADR, 32'h00AB_C000);
        apb(1'b1, REG_CMD, 32'h0000_0010);
        xl(VA);
        `CHK({rv.raddr, n > 1}, {24'hAB_C456, 1'b1})
        apb(1'b1, REG_CMD, 32'h0000_000C);
        xl(VA);
        `CHK({rv.raddr, n > 1}, {24'hAB_C456, 1'b1})
        xl(24'h13_0000);
        `CHK(rv.exc, EXC_SEG)
        for (int k = 1; k <= 5; k++) begin
            apb(1'b1, REG_CR1, (32'(k) << 16) | 32'h0000_000F);
            apb(1'b1, REG_CMD, 32'h0000_0001);
        end
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK(rd[2:0], 3'h1)
        xl(VA);
        `CHK(rv.exc, EXC_PAGE)
        apb(1'b1, REG_CR0, 32'h0000_0300);
        xl(24'h13_0000);
        `CHK({rv.exc, n == 1}, {EXC_SPEC, 1'b1})
        @(posedge pclk);
        buffer_error <= 1'b1;
        @(posedge pclk);
        buffer_error <= 1'b0;
        #1;
        `CHK(machine_check, 1'b1)
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK({rd[ST_MC], rd[ST_DEGR]}, 2'b11)
        apb(1'b1, REG_CMD, 32'h0000_0020);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK(rd[ST_MC], 1'b0)
        end_of_test();
    end
endmodule // tb
`default_nettype wire
